// >>> logic/akr_resolver.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Set-register one enables completion interrupt
// RULE_02 - Match, no-match enable bits, readable
// RULE_03 - Clear-register one disables that interrupt
// RULE_04 - Clear register reads enables, reset zero
// RULE_05 - Status holds last matching key index
// RULE_06 - Two-bit enable: zero off, three on
// RULE_07 - Key count 1..16, resets to one
// RULE_08 - Latency: fixed overhead plus per-key period
// RULE_09 - Eight keys take about 48 microseconds
// RULE_10 - Completion event after every resolution
// RULE_11 - No-match event when no key resolves; a run ended by stop raises none
// RULE_12 - Keys fetched through key table pointer
// RULE_13 - Address fetched through address pointer
// RULE_14 - Scratch pointer area holds intermediate values
// RULE_15 - Keys from zero, stop first match
// RULE_16 - Key i at table plus 16*i
// RULE_17 - Memory accesses finish before events
// RULE_18 - Start ignored while unit disabled
// RULE_19 - Flags sticky until zero written; irq level
module akr_resolver (
	input wire logic pclk, // System clock, 10 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, 1 = write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output akr_pkg::akr_mem_req_t mem_out, // Memory master request
	input wire logic mem_ack, // Memory access done
	input wire logic [31:0] mem_rdata, // Memory read data, valid with ack
	output logic irq // Level interrupt
);
	import akr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Every flop of the block; one register, next value built below
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic [2:0] ev;
		logic [2:0] ie;
		logic [3:0] last_key;
		logic [1:0] unit_en;
		logic [4:0] key_count;
		logic [31:0] key_ptr;
		logic [31:0] addr_ptr;
		logic [31:0] scr_ptr;
		akr_state_t st;
		akr_mem_req_t mreq;
		logic [2:0] wi;
		logic [3:0] idx;
		logic [6:0] cnt;
		logic stop;
		logic hit;
		logic [23:0] calc;
		logic [63:0] addr_w;
		logic [127:0] key_w;
	} akr_regs_t;

	// Registered state and its next value
	akr_regs_t s_reg;
	akr_regs_t s_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Keyed 24-bit fold of key and random part; stands in for the
	// block cipher so the per-key period is a fixed pad, not the core
	// Bit order: key byte i is k[8i+7:8i], word 0 first
	function automatic logic [23:0] akr_hash(input logic [127:0] k,
			input logic [23:0] p);
		logic [23:0] h;
		h = p;
		for (int i = 0; i < 16; i++) begin
			h = {h[22:0], h[23]} ^ {16'h0000, k[8*i +: 8]} ^ p;
		end
		return h;
	endfunction

	// Out-of-range counts are clamped so a run always has 1..16 keys
	function automatic logic [4:0] akr_eff_count(input logic [4:0] c);
		if (c == 5'h00) begin
			return 5'h01;
		end
		if (c > KEY_COUNT_MAX) begin
			return KEY_COUNT_MAX;
		end
		return c;
	endfunction

	// Byte address of word w of record rec in a table at base;
	// the sum wraps at 32 bits, as the pointer space does
	function automatic logic [31:0] akr_word_addr(input logic [31:0] base,
			input logic [3:0] rec, input logic [2:0] w);
		return base + KEY_STRIDE * {28'h0, rec} + WORD_STRIDE * {29'h0, w};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic acc;
		logic wr;
		logic [4:0] n_keys;
		// acc is the first access cycle only; ready high ends the access
		acc = psel && penable && !s_reg.pready;
		wr = acc && pwrite;
		n_keys = akr_eff_count(s_reg.key_count);
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;

		// Bus slave: one wait state, data and ready from flops
		// Reads return the state before this access's own write
		if (acc) begin
			s_next.pready = 1'b1;
			// Write-only and unmapped offsets read as zero
			s_next.prdata = 32'h0000_0000;
			unique case (paddr)
				// Start trigger, write one
				OFS_START: begin
					// Start only takes effect when enabled and idle
					if (wr && pwdata[0] && s_reg.unit_en == UNIT_EN_ON
							&& s_reg.st == ST_IDLE) begin // RULE_18 RULE_06
						s_next.st = ST_ADDR;
						s_next.wi = 3'h0;
						s_next.cnt = 7'h00;
						s_next.stop = 1'b0;
					end
				end
				// Stop trigger, honoured at the end of the current key
				OFS_STOP: begin
					if (wr && pwdata[0] && s_reg.st != ST_IDLE) begin
						s_next.stop = 1'b1;
					end
				end

				// Completion flag
				OFS_EV_DONE: begin
					s_next.prdata[0] = s_reg.ev[EV_DONE_BIT];
					if (wr) begin
						s_next.ev[EV_DONE_BIT] = pwdata[0]; // RULE_19
					end
				end
				// Match flag
				OFS_EV_MATCH: begin
					s_next.prdata[0] = s_reg.ev[EV_MATCH_BIT];
					if (wr) begin
						s_next.ev[EV_MATCH_BIT] = pwdata[0]; // RULE_19
					end
				end
				// No-match flag
				OFS_EV_NOMATCH: begin
					s_next.prdata[0] = s_reg.ev[EV_NOMATCH_BIT];
					if (wr) begin
						s_next.ev[EV_NOMATCH_BIT] = pwdata[0]; // RULE_19
					end
				end

				// Enable set: ones add enables, reads show them
				OFS_IRQ_SET: begin
					s_next.prdata[2:0] = s_reg.ie; // RULE_02
					if (wr) begin
						s_next.ie = s_reg.ie | pwdata[2:0]; // RULE_01 RULE_02
					end
				end
				// Enable clear: ones drop enables, same state
				OFS_IRQ_CLR: begin
					s_next.prdata[2:0] = s_reg.ie; // RULE_04
					if (wr) begin
						s_next.ie = s_reg.ie & ~pwdata[2:0]; // RULE_03
					end
				end

				// Index of the last matching key, read only
				OFS_LAST_KEY: begin
					s_next.prdata[3:0] = s_reg.last_key; // RULE_05
				end

				// Unit enable; only the value three runs the unit
				OFS_UNIT_EN: begin
					s_next.prdata[1:0] = s_reg.unit_en;
					if (wr) begin
						s_next.unit_en = pwdata[1:0]; // RULE_06
					end
				end
				// Key count, clamped on use rather than on write
				OFS_KEY_COUNT: begin
					s_next.prdata[4:0] = s_reg.key_count;
					if (wr) begin
						s_next.key_count = pwdata[4:0]; // RULE_07
					end
				end
				// Key table base
				OFS_KEY_PTR: begin
					s_next.prdata = s_reg.key_ptr;
					if (wr) begin
						s_next.key_ptr = pwdata; // RULE_12
					end
				end
				// Address to resolve
				OFS_ADDR_PTR: begin
					s_next.prdata = s_reg.addr_ptr;
					if (wr) begin
						s_next.addr_ptr = pwdata; // RULE_13
					end
				end
				// Scratch area for computed hashes
				OFS_SCR_PTR: begin
					s_next.prdata = s_reg.scr_ptr;
					if (wr) begin
						s_next.scr_ptr = pwdata; // RULE_14
					end
				end
				default: begin
					s_next.pslverr = 1'b1;
				end
			endcase
		end

		// Run timer; saturates so a slow memory cannot wrap it
		// It restarts at each key, so it times one key at a time
		if (s_reg.st != ST_IDLE && s_reg.cnt != 7'h7f) begin
			s_next.cnt = s_reg.cnt + 7'h01;
		end

		// Memory handshake: request held until acknowledged
		// wi counts completed words of the current fetch
		if (s_reg.mreq.req && mem_ack) begin
			s_next.mreq.req = 1'b0;
			s_next.mreq.we = 1'b0;
			s_next.wi = s_reg.wi + 3'h1;
		end

		// Resolution sequence; hardware sets below bus writes, so set wins
		// An illegal state code returns to idle; that run is lost
		unique case (s_reg.st)
			ST_IDLE: begin
				// Start is decoded with the bus; nothing moves here
			end
			ST_ADDR: begin
				// Six address bytes fetched as two words
				// The second word's top half is not used
				if (s_reg.mreq.req && mem_ack) begin
					s_next.addr_w[32*s_reg.wi[0] +: 32] = mem_rdata;
					if (s_reg.wi == ADDR_WORDS - 3'h1) begin
						s_next.st = ST_OVH;
					end
				end else if (!s_reg.mreq.req) begin
					s_next.mreq.req = 1'b1;
					s_next.mreq.addr = akr_word_addr(s_reg.addr_ptr, 4'h0,
						s_reg.wi); // RULE_13
				end
			end
			ST_OVH: begin
				// Fixed overhead before the first key
				// cnt runs from the start write, so the fetch sits inside it
				if (s_reg.cnt >= OVERHEAD_CYC - 7'h01) begin // RULE_08
					s_next.st = ST_KEY;
					s_next.cnt = 7'h00;
					s_next.wi = 3'h0;
					s_next.idx = 4'h0; // RULE_15
				end
			end
			ST_KEY: begin
				// Four words of key idx, then the calculation
				if (s_reg.mreq.req && mem_ack) begin
					s_next.key_w[32*s_reg.wi[1:0] +: 32] = mem_rdata;
					if (s_reg.wi == KEY_WORDS - 3'h1) begin
						s_next.st = ST_CALC;
					end
				end else if (!s_reg.mreq.req) begin
					s_next.mreq.req = 1'b1;
					s_next.mreq.addr = akr_word_addr(s_reg.key_ptr, s_reg.idx,
						s_reg.wi); // RULE_12 RULE_16
				end
			end
			ST_CALC: begin
				// Hash of random part compared with the hash part
				// The scratch write carries this key's hash for software
				s_next.calc = akr_hash(s_reg.key_w,
					{s_reg.addr_w[47:32], s_reg.addr_w[31:24]});
				s_next.hit = (s_next.calc == s_reg.addr_w[23:0]);
				s_next.mreq.req = 1'b1;
				s_next.mreq.we = 1'b1;
				s_next.mreq.addr = s_reg.scr_ptr; // RULE_14
				s_next.mreq.wdata = {8'h00, s_next.calc};
				s_next.st = ST_SCR;
			end
			ST_SCR: begin
				// Wait for the scratch write to complete
				if (s_reg.mreq.req && mem_ack) begin
					s_next.st = ST_PAD;
				end
			end
			ST_PAD: begin
				// Pad each key to the per-key period; memory is idle here
				// Slow memory eats into the pad, not into the period
				if (s_reg.cnt >= PER_KEY_CYC - 7'h01) begin // RULE_08 RULE_09
					s_next.cnt = 7'h00;
					s_next.wi = 3'h0;
					if (s_reg.hit) begin
						// First match ends the walk
						s_next.ev[EV_MATCH_BIT] = 1'b1; // RULE_15 RULE_17
						s_next.last_key = s_reg.idx; // RULE_05
						s_next.st = ST_DONE;
					end else if (s_reg.stop) begin
						// Stop ends after this key, with no result event
						s_next.st = ST_DONE;
					end else if ({1'b0, s_reg.idx} == n_keys - 5'h01) begin // RULE_07
						// Last configured key tried without a match
						s_next.ev[EV_NOMATCH_BIT] = 1'b1; // RULE_11 RULE_17
						s_next.st = ST_DONE;
					end else begin
						s_next.idx = s_reg.idx + 4'h1; // RULE_15
						s_next.st = ST_KEY;
					end
				end
			end
			ST_DONE: begin
				// Completion follows match or no-match by one cycle
				// Stop is dropped here so the next start begins clean
				s_next.ev[EV_DONE_BIT] = 1'b1; // RULE_10 RULE_17
				s_next.stop = 1'b0;
				s_next.st = ST_IDLE;
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// Level interrupt from the next flags so output is a flop
		s_next.irq = |(s_next.ev & s_next.ie); // RULE_19
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Clear all, then the fields with named reset values
			s_reg <= '0;
			s_reg.ie <= IRQ_EN_RST; // RULE_04
			s_reg.last_key <= LAST_KEY_RST; // RULE_05
			s_reg.unit_en <= UNIT_EN_RST; // RULE_06
			s_reg.key_count <= KEY_COUNT_RST; // RULE_07
			s_reg.key_ptr <= PTR_RST;
			s_reg.addr_ptr <= PTR_RST;
			s_reg.scr_ptr <= PTR_RST;
			s_reg.st <= ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a field of the state register
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign mem_out = s_reg.mreq;
	assign irq = s_reg.irq;

endmodule

// >>> logic/akr_pkg.sv
package akr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_START = 12'h000;
	localparam logic [11:0] OFS_STOP = 12'h008;
	localparam logic [11:0] OFS_EV_DONE = 12'h100;
	localparam logic [11:0] OFS_EV_MATCH = 12'h104;
	localparam logic [11:0] OFS_EV_NOMATCH = 12'h108;
	localparam logic [11:0] OFS_IRQ_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
	localparam logic [11:0] OFS_LAST_KEY = 12'h400;
	localparam logic [11:0] OFS_UNIT_EN = 12'h500;
	localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
	localparam logic [11:0] OFS_KEY_PTR = 12'h508;
	localparam logic [11:0] OFS_ADDR_PTR = 12'h510;
	localparam logic [11:0] OFS_SCR_PTR = 12'h514;

	// ----------------------------------------------------------------
	// Field positions, values and reset values
	// ----------------------------------------------------------------
	localparam int EV_DONE_BIT = 0;
	localparam int EV_MATCH_BIT = 1;
	localparam int EV_NOMATCH_BIT = 2;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	localparam logic [1:0] UNIT_EN_ON = 2'h3;
	localparam logic [1:0] UNIT_EN_RST = 2'h0;
	localparam logic [4:0] KEY_COUNT_RST = 5'h01;
	localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
	localparam logic [3:0] LAST_KEY_RST = 4'h0;
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic [31:0] KEY_STRIDE = 32'h0000_0010;
	localparam logic [31:0] WORD_STRIDE = 32'h0000_0004;
	localparam logic [2:0] ADDR_WORDS = 3'h2;
	localparam logic [2:0] KEY_WORDS = 3'h4;

	// ----------------------------------------------------------------
	// Timing, clock is 100 ns
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int OVERHEAD_NS = 1000;
	localparam int EIGHT_KEY_NS = 48000;
	localparam int per_key_latency_NS = (EIGHT_KEY_NS - OVERHEAD_NS) / 8;
	localparam logic [6:0] OVERHEAD_CYC = 7'((OVERHEAD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [6:0] PER_KEY_CYC = 7'(per_key_latency_NS / CLK_NS);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'b0000_0001,
		ST_ADDR = 8'b0000_0010,
		ST_OVH = 8'b0000_0100,
		ST_KEY = 8'b0000_1000,
		ST_CALC = 8'b0001_0000,
		ST_SCR = 8'b0010_0000,
		ST_PAD = 8'b0100_0000,
		ST_DONE = 8'b1000_0000
	} akr_state_t;

	// Memory master request, held until mem_ack
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} akr_mem_req_t;

endpackage

// >>> dv/akr_monitor.sv
`timescale 1ns/1ps
module akr_monitor (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Direction
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic pready, // Ready
	input akr_pkg::akr_mem_req_t mem_out, // Memory request
	input wire logic mem_ack, // Memory done
	input wire logic irq // Interrupt
);
	import akr_pkg::*;
	logic [1:0] en_reg;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Access steps
	// ----------------------------------------
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_clr;
		s_acc ##0 (pwrite && paddr == OFS_IRQ_CLR && pwdata[2:0] == 3'h7);
	endsequence
	sequence s_off;
		s_acc ##0 (pwrite && paddr == OFS_START && pwdata[0] && en_reg != UNIT_EN_ON
			&& !mem_out.req);
	endsequence
	// Enable mirror, so a refused start is known without peeking inside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= UNIT_EN_RST;
		end else if (psel && penable && !pready && pwrite && paddr == OFS_UNIT_EN) begin
			en_reg <= pwdata[1:0];
		end
	end
	a_ready_wait: assert property (s_acc |=> pready)
		else $error("ready late");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready too long");
	a_irq_reset: assert property ($rose(presetn) |-> !irq)
		else $error("irq after reset");
	a_irq_masked: assert property (s_clr |-> ##2 !irq)
		else $error("irq not masked");
	a_mem_hold: assert property (mem_out.req && !mem_ack |=> $stable(mem_out))
		else $error("request moved");
	a_mem_gap: assert property (mem_out.req && mem_ack |=> !mem_out.req)
		else $error("no request gap");
	a_irq_after_mem: assert property ($rose(irq) |-> !$past(mem_out.req))
		else $error("event during access");
	a_start_off: assert property (s_off |=> !mem_out.req [*8])
		else $error("start not ignored");
endmodule
bind akr_resolver akr_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .mem_out, .mem_ack, .irq);

// >>> dv/akr_mem_model.sv
`timescale 1ns/1ps
module akr_mem_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input akr_pkg::akr_mem_req_t mem_out, // Request
	input wire logic slow, // Stall accesses
	output logic mem_ack, // Done
	output logic [31:0] mem_rdata // Read data
);
	import akr_pkg::*;
	logic [31:0] ram [0:255];
	int stall;
	// RAM with wait states; idle data toggles so a late sample is caught
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			stall = 0;
		end else if (mem_out.req && !mem_ack && stall > 0) begin
			stall--;
			mem_rdata <= ~mem_rdata;
		end else if (mem_out.req && !mem_ack) begin
			mem_ack <= 1'b1;
			stall = slow ? 3 : 0;
			if (mem_out.we) ram[mem_out.addr[9:2]] <= mem_out.wdata;
			else mem_rdata <= ram[mem_out.addr[9:2]];
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// >>> dv/akr_resolver_tb.sv
`timescale 1ns/1ps
module akr_resolver_tb;
	import akr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mem_ack;
	logic [31:0] mem_rdata;
	logic irq;
	akr_mem_req_t mem_out;
	int checks = 0;
	int miscompares = 0;
	int seed = 32'h1887_68c8;
	int lk = 0;
	akr_resolver dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mem_out, .mem_ack, .mem_rdata, .irq);
	akr_mem_model mem_u (.pclk, .presetn, .mem_out, .slow, .mem_ack, .mem_rdata);
	always #50 pclk = ~pclk;
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task summarize;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input bit ok);
		checks++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED at %0t: mismatch", $time);
		end
	endtask
	// One transfer, held until pready is seen, then a single idle cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			miscompares++;
			$display("CHECK FAILED at %0t: no ready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q === x && e === xe);
	endtask
	// Behavioural key table and fold
	function logic [127:0] key(input int i);
		return {mem_u.ram[4*i+3], mem_u.ram[4*i+2], mem_u.ram[4*i+1], mem_u.ram[4*i]};
	endfunction
	function logic [23:0] hsh(input logic [127:0] k, input logic [23:0] p);
		logic [23:0] h;
		h = p;
		for (int i = 0; i < 16; i++) h = {h[22:0], h[23]} ^ {16'h0, k[8*i+:8]} ^ p;
		return h;
	endfunction
	// One resolution against n random keys, key tgt made to match (none if negative);
	// with stp set a stop is written at once, so only key 0 is tried
	task run(input int n, input int tgt, input bit stp);
		logic [23:0] pr;
		logic [23:0] hv;
		int ex;
		int k;
		int c;
		int lim;
		time t0;
		for (int i = 0; i < 64; i++) mem_u.ram[i] = $random(seed);
		pr = 24'($random(seed));
		hv = 24'($random(seed));
		if (tgt >= 0) hv = hsh(key(tgt), pr);
		mem_u.ram[128] = {pr[7:0], hv};
		mem_u.ram[129] = {16'h0, pr[23:8]};
		lim = stp ? 1 : n;
		ex = -1;
		for (int i = 0; i < lim; i++) if (ex < 0 && hsh(key(i), pr) === hv) ex = i;
		k = (ex < 0) ? lim : ex + 1;
		if (ex >= 0) lk = ex;
		wr(OFS_KEY_COUNT, 32'(n));
		rd(OFS_KEY_COUNT, 32'(n), 1'b0);
		wr(OFS_START, 32'h1);
		t0 = $time;
		c = 0;
		if (stp) wr(OFS_STOP, 32'h1);
		while (irq !== 1'b1 && c < 5000) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 5000) begin
			miscompares++;
			$display("CHECK FAILED at %0t: no completion", $time);
		end
		c = int'(($time - t0) / CLK_NS) - int'(OVERHEAD_CYC) - int'(PER_KEY_CYC) * k;
		if (!slow) chk(c >= -4 && c <= 12);
		rd(OFS_EV_MATCH, {31'h0, ex >= 0}, 1'b0);
		rd(OFS_EV_NOMATCH, {31'h0, ex < 0 && !stp}, 1'b0);
		rd(OFS_EV_DONE, 32'h1, 1'b0);
		rd(OFS_LAST_KEY, 32'(lk), 1'b0);
		chk(mem_u.ram[192] === {8'h0, hsh(key(k - 1), pr)});
		wr(OFS_IRQ_CLR, 32'h7);
		chk(irq === 1'b0);
		wr(OFS_IRQ_SET, (ex >= 0) ? 32'h4 : 32'h2);
		chk(irq === 1'b0);
		wr(OFS_IRQ_SET, (ex >= 0) ? 32'h2 : 32'h4);
		chk(irq === (ex >= 0 || !stp));
		wr(OFS_IRQ_CLR, 32'h6);
		wr(OFS_IRQ_SET, 32'h1);
		chk(irq === 1'b1);
		for (int i = 0; i < 3; i++) wr(OFS_EV_DONE + 12'(4 * i), 32'h0);
		chk(irq === 1'b0);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_IRQ_CLR, 32'h0, 1'b0);
		rd(OFS_LAST_KEY, 32'h0, 1'b0);
		rd(OFS_UNIT_EN, 32'h0, 1'b0);
		rd(OFS_KEY_COUNT, 32'h1, 1'b0);
		rd(12'h0fc, 32'h0, 1'b1);
		wr(OFS_IRQ_SET, 32'h7);
		rd(OFS_IRQ_SET, 32'h7, 1'b0);
		wr(OFS_IRQ_CLR, 32'h2);
		rd(OFS_IRQ_CLR, 32'h5, 1'b0);
		wr(OFS_IRQ_CLR, 32'h7);
		wr(OFS_IRQ_SET, 32'h1);
		rd(OFS_IRQ_SET, 32'h1, 1'b0);
		wr(OFS_START, 32'h1);
		repeat (20) @(posedge pclk);
		chk(mem_out.req === 1'b0);
		rd(OFS_EV_DONE, 32'h0, 1'b0);
		wr(OFS_KEY_PTR, 32'h0);
		wr(OFS_ADDR_PTR, 32'h200);
		wr(OFS_SCR_PTR, 32'h300);
		wr(OFS_UNIT_EN, 32'h3);
		rd(OFS_UNIT_EN, 32'h3, 1'b0);
		run(8, 5, 1'b0);
		slow <= 1'b1;
		run(16, -1, 1'b0);
		slow <= 1'b0;
		run(1, 0, 1'b0);
		run(16, -1, 1'b1);
		// Reset in mid-run: registers back to reset values, memory master quiet
		wr(OFS_KEY_COUNT, 32'h10);
		wr(OFS_START, 32'h1);
		repeat (100) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(mem_out.req === 1'b0 && irq === 1'b0);
		rd(OFS_UNIT_EN, 32'h0, 1'b0);
		rd(OFS_KEY_COUNT, 32'h1, 1'b0);
		rd(OFS_IRQ_SET, 32'h0, 1'b0);
		rd(OFS_EV_DONE, 32'h0, 1'b0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		summarize();
	end
endmodule
